// *** logic/sar_ctl_pkg.sv ***
/*
  constants for the converter control block: register offsets, field
  positions, reset values and timing counts.
  assumes a 200 MHz pclk and a 32-bit apb bus.
*/
package sar_ctl_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_ANALOG    = 8'h04;
  localparam logic [7:0] OFS_RES_HIGH  = 8'h08;
  localparam logic [7:0] OFS_RES_LOW   = 8'h0c;
  localparam logic [7:0] OFS_FLAG      = 8'h10;
  localparam logic [7:0] OFS_ENABLE    = 8'h14;

  // converter control fields
  localparam int BIT_FORMAT  = 7;
  localparam int BIT_REF     = 6;
  localparam int BIT_CHAN_HI = 3;
  localparam int BIT_CHAN_LO = 2;
  localparam int BIT_GO      = 1;
  localparam int BIT_ENABLE  = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // analog select fields
  localparam int BIT_CLK_HI = 6;
  localparam int BIT_CLK_LO = 4;
  localparam logic [7:0] ANALOG_RESET = 8'h0f;

  // flag and enable position
  localparam int BIT_COMPLETION = 6;

  // conversion sizing
  localparam int RESULT_W = 10;
  localparam logic [3:0] PERIODS_PER_CONV  = 4'd11;
  localparam logic [1:0] ABORT_WAIT_PERIODS = 2'd2;

  // one instruction is four system clocks
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int INSTR_TIME_PS   = 20000;
  localparam logic [2:0] INSTR_CYCLES = 3'((INSTR_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_DELAY = 5'b00010,
    ST_CONV  = 5'b00100,
    ST_ABORT = 5'b01000,
    ST_WAIT  = 5'b10000
  } conv_state_t;

endpackage : sar_ctl_pkg

// *** logic/sar_adc_conversion_control.sv ***
/*
  control logic of a 10-bit successive-approximation converter with an apb
  register port, conversion clock selection, abort, sleep and trigger handling.
  assumes an external comparator and dac, a free-running dedicated oscillator
  brought in as a pin, and sleep and trigger signals on the pclk domain.
*/
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps

// Contract
// - ten-bit successive approximation into result pair
// - channel field picks the one converted input
// - reference bit picks supply or external pin
// - clock field picks divider or dedicated oscillator
// - one period per bit, eleven per conversion
// - converts only while module enabled
// - writing go one starts a conversion
// - completion clears go, loads result, sets flag
// - flag cleared only by software
// - flag and enable request interrupt and wake
// - vector only with global enable set
// - format bit picks left or right justify
// - go cleared mid-conversion aborts, result kept
// - after abort wait two periods, reacquire
// - reset loads register defaults and stops conversion
// - oscillator source delays start one instruction
// - sleep oscillator no irq powers down after
// - sleep with other clock aborts, powers down
// - trigger sets go and resets timer
// - justified layout of result pair
// - channel codes zero to three
// - reference bit six selects external pin
module sar_adc_conversion_control
  import sar_ctl_pkg::*;
(
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // analog front end
  input  wire logic                comp_above,
  input  wire logic                osc_clk_pin,
  output logic [1:0]               channel_select,
  output logic                     reference_select,
  output logic [RESULT_W-1:0]      trial_code,
  output logic                     acquire,
  output logic                     converter_power,
  // system
  input  wire logic                sleep_active,
  input  wire logic                global_irq_enable,
  input  wire logic                special_trigger,
  output logic                     irq_request,
  output logic                     wake_request,
  output logic                     irq_vector,
  output logic                     timer_reset
);

  conv_state_t          state_reg;
  logic [7:0]           control_reg;
  logic [7:0]           analog_select_reg;
  logic [7:0]           result_high_reg;
  logic [7:0]           result_low_reg;
  logic                 completion_flag;
  logic                 completion_irq_enable;
  logic [5:0]           div_cnt_reg;
  logic                 tick_reg;
  logic [2:0]           osc_sync_reg;
  logic                 comp_sync1_reg;
  logic                 comp_sync2_reg;
  logic [3:0]           period_cnt_reg;
  logic [2:0]           delay_cnt_reg;
  logic [RESULT_W-1:0]  sar_reg;
  logic                 power_off_reg;
  logic                 done_pulse;
  logic                 wr_en;
  logic                 rd_en;
  logic                 wr_control;
  logic                 go_start;
  logic                 go_clear;
  logic                 osc_src;
  logic                 sleep_abort;
  logic [9:0]           final_code;

  function automatic logic [5:0] div_limit(input logic [2:0] sel);
    unique case (sel)
      3'b000:  div_limit = 6'd1;
      3'b100:  div_limit = 6'd3;
      3'b001:  div_limit = 6'd7;
      3'b101:  div_limit = 6'd15;
      3'b010:  div_limit = 6'd31;
      3'b110:  div_limit = 6'd63;
      default: div_limit = 6'd0;
    endcase
  endfunction : div_limit

  // bus decode
  assign wr_en      = psel & penable & pwrite & pready;
  assign rd_en      = psel & ~penable & ~pwrite;
  assign wr_control = wr_en & (paddr == OFS_CONTROL);
  assign osc_src    = analog_select_reg[BIT_CLK_LO +: 2] == 2'b11;
  assign go_start   = control_reg[BIT_ENABLE] &
                      ((wr_control & pwdata[BIT_GO] & ~control_reg[BIT_GO]) | special_trigger);
  assign go_clear   = wr_control & ~pwdata[BIT_GO] & control_reg[BIT_GO];
  assign sleep_abort = sleep_active & ~osc_src & (state_reg != ST_IDLE) & (state_reg != ST_WAIT);
  assign done_pulse = (state_reg == ST_CONV) & tick_reg & (period_cnt_reg == PERIODS_PER_CONV - 4'd1)
                      & ~go_clear & ~sleep_abort;
  assign final_code = comp_sync2_reg ? sar_reg : (sar_reg & ~(10'h001));

  // apb answer, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > OFS_ENABLE || paddr[1:0] != 2'b00);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (paddr)
        OFS_CONTROL:  prdata <= {24'h00_0000, control_reg};
        OFS_ANALOG:   prdata <= {24'h00_0000, analog_select_reg};
        OFS_RES_HIGH: prdata <= {24'h00_0000, result_high_reg};
        OFS_RES_LOW:  prdata <= {24'h00_0000, result_low_reg};
        OFS_FLAG:     prdata <= {24'h00_0000, 1'b0, completion_flag, 6'h00};
        OFS_ENABLE:   prdata <= {24'h00_0000, 1'b0, completion_irq_enable, 6'h00};
        default:      prdata <= 32'h0000_0000;
      endcase
    end
  end

  // control register, go bit owned by hardware sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= CONTROL_RESET;
    end else begin
      if (wr_control) begin
        control_reg[BIT_FORMAT] <= pwdata[BIT_FORMAT];
        control_reg[BIT_REF]    <= pwdata[BIT_REF];
        control_reg[BIT_CHAN_HI:BIT_CHAN_LO] <= pwdata[BIT_CHAN_HI:BIT_CHAN_LO];
        control_reg[BIT_ENABLE] <= pwdata[BIT_ENABLE];
      end
      if (go_start && (state_reg == ST_IDLE)) begin
        control_reg[BIT_GO] <= 1'b1;
      end else if (done_pulse || go_clear || sleep_abort
                   || (wr_control && !pwdata[BIT_ENABLE])) begin
        control_reg[BIT_GO] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_select_reg <= ANALOG_RESET;
    end else if (wr_en && paddr == OFS_ANALOG) begin
      analog_select_reg <= {1'b0, pwdata[6:0]};
    end
  end

  // completion flag: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      completion_flag <= 1'b0;
    end else if (done_pulse) begin
      completion_flag <= 1'b1;
    end else if (wr_en && paddr == OFS_FLAG) begin
      completion_flag <= pwdata[BIT_COMPLETION];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      completion_irq_enable <= 1'b0;
    end else if (wr_en && paddr == OFS_ENABLE) begin
      completion_irq_enable <= pwdata[BIT_COMPLETION];
    end
  end

  // dedicated oscillator and comparator synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync_reg   <= 3'b000;
      comp_sync1_reg <= 1'b0;
      comp_sync2_reg <= 1'b0;
    end else begin
      osc_sync_reg   <= {osc_sync_reg[1:0], osc_clk_pin};
      comp_sync1_reg <= comp_above;
      comp_sync2_reg <= comp_sync1_reg;
    end
  end

  // bit period tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 6'd0;
      tick_reg    <= 1'b0;
    end else if (osc_src) begin
      div_cnt_reg <= 6'd0;
      tick_reg    <= osc_sync_reg[1] & ~osc_sync_reg[2];
    end else if (div_cnt_reg >= div_limit(analog_select_reg[BIT_CLK_HI:BIT_CLK_LO])) begin
      div_cnt_reg <= 6'd0;
      tick_reg    <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 6'd1;
      tick_reg    <= 1'b0;
    end
  end

  // conversion sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= ST_IDLE;
      period_cnt_reg <= 4'd0;
      delay_cnt_reg  <= 3'd0;
      sar_reg        <= 10'h000;
    end else if (!control_reg[BIT_ENABLE]) begin
      state_reg      <= ST_IDLE;
      period_cnt_reg <= 4'd0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (go_start) begin
            period_cnt_reg <= 4'd0;
            delay_cnt_reg  <= 3'd0;
            sar_reg        <= 10'h200;
            state_reg      <= osc_src ? ST_DELAY : ST_CONV;
          end
        end
        ST_DELAY: begin
          if (go_clear || sleep_abort) begin
            state_reg <= ST_ABORT;
          end else if (delay_cnt_reg == INSTR_CYCLES - 3'd1) begin
            state_reg <= ST_CONV;
          end else begin
            delay_cnt_reg <= delay_cnt_reg + 3'd1;
          end
        end
        ST_CONV: begin
          if (go_clear || sleep_abort) begin
            state_reg      <= ST_ABORT;
            period_cnt_reg <= 4'd0;
          end else if (tick_reg) begin
            if (done_pulse) begin
              state_reg <= ST_IDLE;
            end else begin
              period_cnt_reg <= period_cnt_reg + 4'd1;
            end
            if (period_cnt_reg != 4'd0) begin
              // keep or drop the trial bit, then try the next lower one
              sar_reg <= (comp_sync2_reg ? sar_reg : (sar_reg & ~(10'h200 >> (period_cnt_reg - 4'd1))))
                         | (10'h200 >> period_cnt_reg);
            end
          end
        end
        ST_ABORT: begin
          period_cnt_reg <= 4'd0;
          state_reg      <= ST_WAIT;
        end
        ST_WAIT: begin
          if (tick_reg) begin
            if (period_cnt_reg == {2'b00, ABORT_WAIT_PERIODS} - 4'd1) begin
              state_reg <= ST_IDLE;
            end else begin
              period_cnt_reg <= period_cnt_reg + 4'd1;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // result pair loads only on completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_high_reg <= 8'h00;
      result_low_reg  <= 8'h00;
    end else if (done_pulse) begin
      if (control_reg[BIT_FORMAT]) begin
        result_high_reg <= {6'h00, final_code[9:8]};
        result_low_reg  <= final_code[7:0];
      end else begin
        result_high_reg <= final_code[9:2];
        result_low_reg  <= {final_code[1:0], 6'h00};
      end
    end
  end

  // sleep power-down latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_off_reg <= 1'b0;
    end else if (!sleep_active) begin
      power_off_reg <= 1'b0;
    end else if (sleep_abort) begin
      power_off_reg <= 1'b1;
    end else if (done_pulse && osc_src && !completion_irq_enable) begin
      power_off_reg <= 1'b1;
    end
  end

  // analog and system outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_select   <= 2'b00;
      reference_select <= 1'b0;
      trial_code       <= 10'h000;
      acquire          <= 1'b0;
      converter_power  <= 1'b0;
      irq_request      <= 1'b0;
      wake_request     <= 1'b0;
      irq_vector       <= 1'b0;
      timer_reset      <= 1'b0;
    end else begin
      channel_select   <= control_reg[BIT_CHAN_HI:BIT_CHAN_LO];
      reference_select <= control_reg[BIT_REF];
      trial_code       <= sar_reg;
      acquire          <= control_reg[BIT_ENABLE] & ~power_off_reg & (state_reg == ST_IDLE);
      converter_power  <= control_reg[BIT_ENABLE] & ~power_off_reg;
      irq_request      <= completion_flag & completion_irq_enable;
      wake_request     <= completion_flag & completion_irq_enable & sleep_active;
      irq_vector       <= completion_flag & completion_irq_enable & global_irq_enable;
      timer_reset      <= special_trigger & control_reg[BIT_ENABLE];
    end
  end

  // checks
  sequence s_done;
    done_pulse;
  endsequence

  property p_done_clears_go;
    @(posedge pclk) disable iff (!presetn) s_done |=> !control_reg[BIT_GO];
  endproperty
  a_done_clears_go: assert property (p_done_clears_go) else $error("go not cleared at completion");

  property p_done_sets_flag;
    @(posedge pclk) disable iff (!presetn) s_done |=> completion_flag;
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag) else $error("flag not set at completion");

  property p_flag_sticky;
    @(posedge pclk) disable iff (!presetn)
      completion_flag && !(wr_en && paddr == OFS_FLAG) |=> completion_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag fell without software");

  property p_abort_keeps_result;
    @(posedge pclk) disable iff (!presetn)
      state_reg == ST_CONV && (go_clear || sleep_abort) |=> $stable(result_high_reg) && $stable(result_low_reg);
  endproperty
  a_abort_keeps_result: assert property (p_abort_keeps_result) else $error("result changed on abort");

  property p_irq_follows;
    @(posedge pclk) disable iff (!presetn)
      completion_flag && completion_irq_enable |=> irq_request;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt request missing");

  property p_vector_needs_gie;
    @(posedge pclk) disable iff (!presetn) irq_vector |-> $past(global_irq_enable);
  endproperty
  a_vector_needs_gie: assert property (p_vector_needs_gie) else $error("vector without global enable");

  property p_disabled_idle;
    @(posedge pclk) disable iff (!presetn)
      !control_reg[BIT_ENABLE] |=> state_reg == ST_IDLE;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("converting while disabled");

  property p_osc_delay;
    @(posedge pclk) disable iff (!presetn)
      state_reg == ST_IDLE && go_start && osc_src && control_reg[BIT_ENABLE] |=>
        state_reg == ST_DELAY [*4] ##1 state_reg == ST_CONV;
  endproperty
  a_osc_delay: assert property (p_osc_delay) else $error("oscillator start not delayed");

  property p_trigger_timer;
    @(posedge pclk) disable iff (!presetn)
      special_trigger && control_reg[BIT_ENABLE] |=> timer_reset;
  endproperty
  a_trigger_timer: assert property (p_trigger_timer) else $error("timer not reset on trigger");

  property p_wait_two;
    @(posedge pclk) disable iff (!presetn)
      state_reg == ST_ABORT && control_reg[BIT_ENABLE] |=> state_reg == ST_WAIT [*2];
  endproperty
  a_wait_two: assert property (p_wait_two) else $error("abort wait too short");

endmodule : sar_adc_conversion_control

// *** bench/sar_adc_conversion_control_tb.sv ***
/*
  self-checking bench for the converter control block: apb tasks, comparator
  model, dedicated oscillator and a scenario sequence.
  assumes the design package and a 200 MHz pclk.
*/
`timescale 1ns/1ps
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module sar_adc_conversion_control_tb
  import sar_ctl_pkg::*;
;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, q;
  logic                comp_above = 1'b0;
  logic                osc_clk_pin = 1'b0;
  logic                reference_select, acquire, converter_power;
  logic [1:0]          channel_select;
  logic [RESULT_W-1:0] trial_code, vin, held;
  logic                sleep_active, global_irq_enable, special_trigger;
  logic                irq_request, wake_request, irq_vector, timer_reset;
  logic [4:0]          osc_div = 5'h00;
  logic [2:0]          codes [8] = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110, 3'b011, 3'b111};
  int                  per [8] = '{2, 4, 8, 16, 32, 64, 32, 32};
  int                  bad_count, tests_run, n, t0, k;
  int                  cyc = 0;

  sar_adc_conversion_control i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .comp_above(comp_above), .osc_clk_pin(osc_clk_pin), .channel_select(channel_select),
    .reference_select(reference_select), .trial_code(trial_code), .acquire(acquire),
    .converter_power(converter_power), .sleep_active(sleep_active),
    .global_irq_enable(global_irq_enable), .special_trigger(special_trigger),
    .irq_request(irq_request), .wake_request(wake_request), .irq_vector(irq_vector),
    .timer_reset(timer_reset)
  );

  always #2.5 pclk = ~pclk;

  // oscillator of 32 pclk, comparator model, hang limit
  always @(posedge pclk) begin
    osc_div <= osc_div + 5'h01;
    osc_clk_pin <= osc_div[4];
    comp_above <= (vin >= trial_code);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHECK(q & m, e)
  endtask : chk_rd

  task automatic start_conv(input logic [7:0] c);
    t0 = int'($time);
    apb(1'b1, OFS_CONTROL, {24'h0, c | 8'h02});
  endtask : start_conv

  task automatic wait_done();
    do begin
      apb(1'b0, OFS_CONTROL, 32'h0);
    end while (q[BIT_GO] !== 1'b0);
    n = (int'($time) - t0) / 5;
  endtask : wait_done

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  task automatic chk_idle();
    chk_rd(OFS_CONTROL, 32'hff, {24'h0, CONTROL_RESET});
    chk_rd(OFS_ANALOG, 32'hff, {24'h0, ANALOG_RESET});
    chk_rd(OFS_FLAG, 32'h40, 32'h0);
    chk_rd(OFS_ENABLE, 32'h40, 32'h0);
  endtask : chk_idle

  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask : settle

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {sleep_active, global_irq_enable, special_trigger, bad_count, tests_run} = '0;
    vin = 10'h2b5;
    do_reset();
    chk_idle();
    apb(1'b0, 8'h18, 32'h0);
    `CHECK({err, q}, 33'h100000000)
    // go refused while disabled
    apb(1'b1, OFS_CONTROL, 32'h02);
    repeat (20) @(posedge pclk);
    chk_rd(OFS_CONTROL, 32'h03, 32'h0);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFS_CONTROL, {24'h0, 1'b0, i[2], 2'b00, i[1:0], 2'b00});
      settle();
      `CHECK(channel_select, i[1:0])
      `CHECK(reference_select, i[2])
    end
    apb(1'b1, OFS_ANALOG, {24'h0, 1'b0, 3'b001, 4'hf});
    apb(1'b1, OFS_CONTROL, 32'h01);
    repeat (20) @(posedge pclk);
    // both result layouts
    for (int f = 0; f < 2; f++) begin
      start_conv({f[0], 7'h01});
      wait_done();
      `CHECK(n >= 80 && n <= 108, 1'b1)
      chk_rd(OFS_RES_HIGH, f ? 32'h03 : 32'hff, f ? {30'h0, vin[9:8]} : {24'h0, vin[9:2]});
      chk_rd(OFS_RES_LOW, f ? 32'hff : 32'hc0, f ? {24'h0, vin[7:0]} : {24'h0, vin[1:0], 6'h0});
      repeat (100) @(posedge pclk);
      chk_rd(OFS_FLAG, 32'h40, 32'h40);
      apb(1'b1, OFS_FLAG, 32'h0);
      chk_rd(OFS_FLAG, 32'h40, 32'h0);
    end
    // every clock source
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFS_ANALOG, {24'h0, 1'b0, codes[i], 4'hf});
      start_conv(8'h01);
      wait_done();
      `CHECK(n >= 10 * per[i] && n <= 12 * per[i] + 20, 1'b1)
    end
    // abort keeps the old result
    apb(1'b1, OFS_ANALOG, {24'h0, 1'b0, 3'b001, 4'hf});
    start_conv(8'h01);
    wait_done();
    held = vin;
    vin = 10'h14a;
    start_conv(8'h01);
    repeat (30) @(posedge pclk);
    apb(1'b1, OFS_CONTROL, 32'h01);
    `CHECK(acquire, 1'b0)
    k = 0;
    while (acquire !== 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    `CHECK(k >= 8 && k <= 40, 1'b1)
    chk_rd(OFS_RES_HIGH, 32'hff, {24'h0, held[9:2]});
    chk_rd(OFS_CONTROL, 32'h03, 32'h01);
    // interrupt, wake and vector
    apb(1'b1, OFS_FLAG, 32'h0);
    apb(1'b1, OFS_ENABLE, 32'h40);
    apb(1'b1, OFS_FLAG, 32'h40);
    global_irq_enable <= 1'b1;
    sleep_active <= 1'b1;
    settle();
    `CHECK({irq_request, wake_request}, 2'b11)
    `CHECK(irq_vector, 1'b1)
    @(posedge pclk);
    global_irq_enable <= 1'b0;
    settle();
    `CHECK({irq_vector, wake_request}, 2'b01)
    @(posedge pclk);
    sleep_active <= 1'b0;
    apb(1'b1, OFS_FLAG, 32'h0);
    apb(1'b1, OFS_ENABLE, 32'h0);
    settle();
    `CHECK(irq_request, 1'b0)
    // hardware trigger
    @(posedge pclk);
    special_trigger <= 1'b1;
    @(posedge pclk);
    special_trigger <= 1'b0;
    #1;
    `CHECK(timer_reset, 1'b1)
    chk_rd(OFS_CONTROL, 32'h02, 32'h02);
    wait_done();
    chk_rd(OFS_FLAG, 32'h40, 32'h40);
    // sleep with a divided clock aborts
    apb(1'b1, OFS_FLAG, 32'h0);
    start_conv(8'h01);
    repeat (20) @(posedge pclk);
    sleep_active <= 1'b1;
    settle();
    `CHECK(converter_power, 1'b0)
    chk_rd(OFS_CONTROL, 32'h03, 32'h01);
    chk_rd(OFS_FLAG, 32'h40, 32'h0);
    sleep_active <= 1'b0;
    // sleep with the oscillator completes, then powers down
    apb(1'b1, OFS_ANALOG, {24'h0, 1'b0, 3'b011, 4'hf});
    start_conv(8'h01);
    sleep_active <= 1'b1;
    repeat (100) @(posedge pclk);
    `CHECK(converter_power, 1'b1)
    repeat (500) @(posedge pclk);
    `CHECK(converter_power, 1'b0)
    chk_rd(OFS_CONTROL, 32'h03, 32'h01);
    chk_rd(OFS_FLAG, 32'h40, 32'h40);
    sleep_active <= 1'b0;
    // reset in mid conversion
    apb(1'b1, OFS_ANALOG, {24'h0, 1'b0, 3'b001, 4'hf});
    start_conv(8'h01);
    repeat (20) @(posedge pclk);
    do_reset();
    chk_idle();
    complete_run();
  end
endmodule : sar_adc_conversion_control_tb
